// [inc/ioix_consts.svh]
/*
  offsets, field positions, reset values of the interrupt extender.
  assumes: included by bare name, word-aligned 32-bit apb map.
*/
`ifndef IOIX_CONSTS_SVH
`define IOIX_CONSTS_SVH

`define IOIX_OFS_ENABLE   12'h000
`define IOIX_OFS_STATUS   12'h004
`define IOIX_OFS_CLEAR    12'h008
`define IOIX_OFS_PENDING  12'h00C
`define IOIX_OFS_IRQEN    12'h010
`define IOIX_OFS_IRQSTAT  12'h014
`define IOIX_OFS_IRQCLR   12'h018
`define IOIX_OFS_IDENT    12'h01C

`define IOIX_DATA_LSB     0
`define IOIX_SERV_LSB     8
`define IOIX_ENABLE_RST   16'h0000
`define IOIX_IRQEN_RST    2'b00
`define IOIX_SOURCE_ID    8'h5A
`define IOIX_PRIORITY     4'h3

`endif

// [inc/ioix_pkg.sv]
/*
  types shared by the interrupt extender files.
  assumes: nothing beyond the constants header.
*/
package ioix_pkg;
  typedef logic [15:0] ioix_word_t;
  typedef logic [7:0]  ioix_group_t;
endpackage

// [src/ioix_group.sv]
/*
  one interrupt group: eight enabled, sticky request latches.
  assumes: inputs already synchronised to clk.
*/
`timescale 1ns/100ps
`default_nettype none
module ioix_group
  import ioix_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] level_in,
  input  wire logic [WIDTH-1:0] enable,
  input  wire logic [WIDTH-1:0] clear,
  output logic      [WIDTH-1:0] latch,
  output logic      [WIDTH-1:0] rise,
  output logic                  req
);
  // elaboration-time refusal: the status map holds eight bits per group
  if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
    $error("ioix_group width must be 1..8");
  end

  logic [WIDTH-1:0] prev_reg;
  logic [WIDTH-1:0] latch_reg;
  logic [WIDTH-1:0] latch_next;

  // edge, so a stuck-true input can be cleared and stay cleared
  assign rise       = level_in & ~prev_reg & enable;
  // set wins over clear in the same cycle
  assign latch_next = (latch_reg & ~clear) | rise;
  assign latch      = latch_reg;
  assign req        = |latch_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_reg  <= '0;
      latch_reg <= '0;
    end else begin
      prev_reg  <= level_in;
      latch_reg <= latch_next;
    end
  end
endmodule
`default_nettype wire

// [src/ioix_top.sv]
/*
  io interrupt extender: two groups of eight sublevels on apb.
  assumes: single 40 MHz clock, async external inputs, apb master.
*/
// The address map and the APB interface to the registers were decided locally.
// What this block does
// - two groups, data and service, eight input sublevels each
// - all sublevels report one shared source id and priority
// - each of sixteen sublevels has its own software enable
// - each request latch cleared alone by software write
// - any enabled input of a group rising raises that group's request
// - data group drives data line, service group drives service line
`timescale 1ns/100ps
`default_nettype none
`include "ioix_consts.svh"
module ioix_top
  import ioix_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RSTN,
  input  wire logic [7:0]  DATA_IN,
  input  wire logic [7:0]  SERV_IN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             DATA_IRQ,
  output logic             SERV_IRQ,
  output logic             IRQ
);
  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  ioix_word_t sync1_reg;
  ioix_word_t sync2_reg;
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {SERV_IN, DATA_IN};
      sync2_reg <= sync1_reg;
    end
  end

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  ioix_word_t  enable_reg;
  logic [1:0]  irqen_reg;
  logic [1:0]  irqstat_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  wire         access  = PSEL & PENABLE & ~pready_reg;
  wire         wr      = access & PWRITE;
  wire         rd      = access & ~PWRITE;
  wire         hit_en  = PADDR == `IOIX_OFS_ENABLE;
  wire         hit_st  = PADDR == `IOIX_OFS_STATUS;
  wire         hit_cl  = PADDR == `IOIX_OFS_CLEAR;
  wire         hit_pd  = PADDR == `IOIX_OFS_PENDING;
  wire         hit_ie  = PADDR == `IOIX_OFS_IRQEN;
  wire         hit_is  = PADDR == `IOIX_OFS_IRQSTAT;
  wire         hit_ic  = PADDR == `IOIX_OFS_IRQCLR;
  wire         hit_id  = PADDR == `IOIX_OFS_IDENT;
  wire         mapped  = hit_en | hit_st | hit_cl | hit_pd |
                         hit_ie | hit_is | hit_ic | hit_id;
  // clear is write-only; a write of one drops only that latch
  wire ioix_word_t clr_w = (wr && hit_cl) ? PWDATA[15:0] : '0;
  wire [1:0]   iclr_w  = (wr && hit_ic) ? PWDATA[1:0] : 2'b00;

  // ---------------------------------------------------------------
  // sublevel groups
  // ---------------------------------------------------------------
  ioix_group_t data_latch;
  ioix_group_t serv_latch;
  ioix_group_t data_rise;
  ioix_group_t serv_rise;
  logic        data_req;
  logic        serv_req;

  ioix_group #(.WIDTH(8)) u_data (
    .clk      (MCLK),
    .rst_n    (RSTN),
    .level_in (sync2_reg[`IOIX_DATA_LSB +: 8]),
    .enable   (enable_reg[`IOIX_DATA_LSB +: 8]),
    .clear    (clr_w[`IOIX_DATA_LSB +: 8]),
    .latch    (data_latch),
    .rise     (data_rise),
    .req      (data_req)
  );

  ioix_group #(.WIDTH(8)) u_serv (
    .clk      (MCLK),
    .rst_n    (RSTN),
    .level_in (sync2_reg[`IOIX_SERV_LSB +: 8]),
    .enable   (enable_reg[`IOIX_SERV_LSB +: 8]),
    .clear    (clr_w[`IOIX_SERV_LSB +: 8]),
    .latch    (serv_latch),
    .rise     (serv_rise),
    .req      (serv_req)
  );

  wire ioix_word_t status_w  = {serv_latch, data_latch};
  wire ioix_word_t pending_w = status_w & enable_reg;
  // one identity for every sublevel: the host tells them apart by reading status
  wire [31:0]  ident_w   = {20'h0_0000, `IOIX_PRIORITY,
                            `IOIX_SOURCE_ID};
  wire [1:0]   ev_w      = {|serv_rise, |data_rise};
  wire [1:0]   istat_nx  = (irqstat_reg & ~iclr_w) | ev_w;

  wire [31:0]  rmux_w =
      hit_en ? {16'h0000, enable_reg} :
      hit_st ? {16'h0000, status_w} :
      hit_pd ? {16'h0000, pending_w} :
      hit_ie ? {30'h0000_0000, irqen_reg} :
      hit_is ? {30'h0000_0000, irqstat_reg} :
      hit_id ? ident_w : 32'h0000_0000;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      enable_reg  <= `IOIX_ENABLE_RST;
      irqen_reg   <= `IOIX_IRQEN_RST;
      irqstat_reg <= 2'b00;
    end else begin
      if (wr && hit_en) begin
        enable_reg <= PWDATA[15:0];
      end
      if (wr && hit_ie) begin
        irqen_reg <= PWDATA[1:0];
      end
      irqstat_reg <= istat_nx;
    end
  end

  // one wait state: ready rises the cycle after penable
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= access;
      pslverr_reg <= access & ~mapped;
      prdata_reg  <= rd ? rmux_w : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // party lines and interrupt output
  // ---------------------------------------------------------------
  logic data_irq_reg;
  logic serv_irq_reg;
  logic irq_reg;
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      data_irq_reg <= 1'b0;
      serv_irq_reg <= 1'b0;
      irq_reg      <= 1'b0;
    end else begin
      data_irq_reg <= data_req;
      serv_irq_reg <= serv_req;
      irq_reg      <= |(istat_nx & irqen_reg);
    end
  end

  assign PRDATA   = prdata_reg;
  assign PREADY   = pready_reg;
  assign PSLVERR  = pslverr_reg;
  assign DATA_IRQ = data_irq_reg;
  assign SERV_IRQ = serv_irq_reg;
  assign IRQ      = irq_reg;
endmodule
`default_nettype wire

// [testbench/ioix_assertions.sv]
/* port checker of the interrupt extender.
   assumes: bound to ioix_top, header on the include path. */
`timescale 1ns/100ps
`default_nettype none
`include "ioix_consts.svh"
module ioix_assertions (
  input wire logic        MCLK,
  input wire logic        RSTN,
  input wire logic [7:0]  DATA_IN,
  input wire logic [7:0]  SERV_IN,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        DATA_IRQ,
  input wire logic        SERV_IRQ,
  input wire logic        IRQ
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  wire logic clr_wr;
  assign clr_wr = PREADY && PWRITE && PADDR == `IOIX_OFS_CLEAR;
  AST_WAIT: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready late");
  AST_PULSE: assert property (PREADY |=> !PREADY) else $error("ready held");
  AST_ERR: assert property (PREADY && PADDR > `IOIX_OFS_IDENT |-> PSLVERR)
    else $error("no error on unmapped");
  AST_RDZ: assert property (!PREADY |-> PRDATA == 32'h0000_0000)
    else $error("read data outside ready");
  AST_ID: assert property (PREADY && !PWRITE && PADDR == `IOIX_OFS_IDENT
    |-> PRDATA == {20'h0_0000, `IOIX_PRIORITY, `IOIX_SOURCE_ID})
    else $error("identity wrong");
  AST_DSET: assert property ($rose(DATA_IRQ)
    |-> ($past(DATA_IN, 4) | $past(DATA_IN, 5) | $past(DATA_IN, 6)) != 0)
    else $error("data line rose without input");
  AST_SSET: assert property ($rose(SERV_IRQ)
    |-> ($past(SERV_IN, 4) | $past(SERV_IN, 5) | $past(SERV_IN, 6)) != 0)
    else $error("service line rose without input");
  AST_DFALL: assert property ($fell(DATA_IRQ)
    |-> $past(clr_wr) || $past(clr_wr, 2) || $past(clr_wr, 3))
    else $error("data line fell without clear");
  AST_SFALL: assert property ($fell(SERV_IRQ)
    |-> $past(clr_wr) || $past(clr_wr, 2) || $past(clr_wr, 3))
    else $error("service line fell without clear");
  AST_IRQ: assert property ($rose(IRQ) |-> ##[0:2] (DATA_IRQ || SERV_IRQ))
    else $error("irq without party line");
  cover property ($rose(DATA_IRQ));
  cover property ($rose(SERV_IRQ));
  cover property (PSLVERR);
endmodule
bind ioix_top ioix_assertions u_chk (
  .MCLK     (MCLK),
  .RSTN     (RSTN),
  .DATA_IN  (DATA_IN),
  .SERV_IN  (SERV_IN),
  .PSEL     (PSEL),
  .PENABLE  (PENABLE),
  .PWRITE   (PWRITE),
  .PADDR    (PADDR),
  .PRDATA   (PRDATA),
  .PREADY   (PREADY),
  .PSLVERR  (PSLVERR),
  .DATA_IRQ (DATA_IRQ),
  .SERV_IRQ (SERV_IRQ),
  .IRQ      (IRQ)
);
`default_nettype wire

// [testbench/ioix_src_model.sv]
/* far side: external sources of the sixteen sublevel inputs.
   assumes: bench sets the wanted level per sublevel. */
`timescale 1ns/100ps
`default_nettype none
module ioix_src_model (
  input  wire logic        clk,
  input  wire logic [15:0] lvl,
  output var  logic [7:0]  data_out,
  output var  logic [7:0]  serv_out
);
  // levels move just after an edge and are held long, as slow contacts do
  // one driver only; the design's reset covers the unknown first cycle
  always @(posedge clk) {serv_out, data_out} <= lvl;
endmodule
`default_nettype wire

// [testbench/tb_io_interrupt_extender.sv]
/* self-checking bench of the interrupt extender over apb.
   assumes: design, source model and checker compiled first. */
`timescale 1ns/100ps
`default_nettype none
`include "ioix_consts.svh"
module tb_io_interrupt_extender;
  import ioix_pkg::*;
  logic        mclk = 1'b0, rstn = 1'b0, err;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdata;
  logic        pready, pslverr, data_irq, serv_irq, irq;
  logic [7:0]  data_in, serv_in;
  ioix_word_t  lvl = 16'h0000;
  int          bad_count = 0, checks_done = 0, cyc = 0;
  always #12.5 mclk = ~mclk;
  ioix_src_model src (.clk(mclk), .lvl(lvl), .data_out(data_in),
    .serv_out(serv_in));
  ioix_top dut (.MCLK(mclk), .RSTN(rstn), .DATA_IN(data_in),
    .SERV_IN(serv_in), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .DATA_IRQ(data_irq), .SERV_IRQ(serv_irq), .IRQ(irq));
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // reads happen before this edge's updates land, so values are settled
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // no timeout of its own: pready or the global cycle limit ends this wait
    do @(posedge mclk); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, string s);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rdata, e, s);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      test_done();
    end
  end
  initial begin
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    rd(`IOIX_OFS_ENABLE, 32'(`IOIX_ENABLE_RST), "enable rst");
    rd(`IOIX_OFS_IRQEN, 32'(`IOIX_IRQEN_RST), "irqen rst");
    rd(`IOIX_OFS_IDENT, {20'h0_0000, `IOIX_PRIORITY, `IOIX_SOURCE_ID},
       "ident");
    chk(32'(err), 32'h0000_0000, "no slverr");
    $display("reset test done");
    wr(`IOIX_OFS_ENABLE, 32'h0000_FF0F);
    wr(`IOIX_OFS_IRQEN, 32'h0000_0003);
    lvl <= 16'h0111;
    repeat (6) @(posedge mclk);
    rd(`IOIX_OFS_STATUS, 32'h0000_0101, "status");
    rd(`IOIX_OFS_PENDING, 32'h0000_0101, "pending");
    chk(32'({irq, data_irq, serv_irq}), 32'h0000_0007, "lines");
    rd(`IOIX_OFS_IRQSTAT, 32'h0000_0003, "irq status");
    wr(`IOIX_OFS_IRQCLR, 32'h0000_0003);
    wr(`IOIX_OFS_CLEAR, 32'h0000_0001);
    repeat (3) @(posedge mclk);
    rd(`IOIX_OFS_STATUS, 32'h0000_0100, "clear one");
    chk(32'({irq, data_irq, serv_irq}), 32'h0000_0001, "after clr");
    $display("single sublevel test done");
    wr(`IOIX_OFS_ENABLE, 32'h0000_FFFF);
    lvl <= 16'h0000;
    repeat (4) @(posedge mclk);
    lvl <= 16'hFFFF;
    repeat (6) @(posedge mclk);
    rd(`IOIX_OFS_STATUS, 32'h0000_FFFF, "all sixteen");
    wr(`IOIX_OFS_ENABLE, 32'h0000_0000);
    rd(`IOIX_OFS_STATUS, 32'h0000_FFFF, "latch holds");
    wr(`IOIX_OFS_CLEAR, 32'h0000_FFFF);
    rd(`IOIX_OFS_STATUS, 32'h0000_0000, "all clear");
    wr(`IOIX_OFS_STATUS, 32'h0000_FFFF);
    rd(`IOIX_OFS_STATUS, 32'h0000_0000, "status ro");
    rd(`IOIX_OFS_CLEAR, 32'h0000_0000, "clear wo");
    rd(`IOIX_OFS_IRQSTAT, 32'h0000_0003, "irq stat again");
    chk(32'(irq), 32'h0000_0001, "irq held");
    rd(12'h020, 32'h0000_0000, "unmapped");
    chk(32'(err), 32'h0000_0001, "slverr");
    $display("group test done");
    // mid-run reset with every input high: nothing may latch after it
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(32'({irq, data_irq, serv_irq, pready, pslverr}), 32'h0000_0000,
        "outs in reset");
    chk(prdata, 32'h0000_0000, "prdata in reset");
    rstn <= 1'b1;
    rd(`IOIX_OFS_ENABLE, 32'h0000_0000, "enable rerst");
    repeat (6) @(posedge mclk);
    rd(`IOIX_OFS_STATUS, 32'h0000_0000, "no latch");
    rd(`IOIX_OFS_IRQSTAT, 32'h0000_0000, "irqstat rst");
    chk(32'({irq, data_irq, serv_irq}), 32'h0000_0000, "lines rst");
    $display("mid-run reset test done");
    test_done();
  end
endmodule
`default_nettype wire
